// [rtl/rpd_phase_shift.sv]
// Purpose: 90 degree phase shift of the current channel
// Assumes: line frequency well above the leaky integrator corner
// Notes:   output lags by 90 deg; negated when the integrator is off
`timescale 1ns/10ps
`default_nettype none
module rpd_phase_shift #(
  parameter int K = rpd_pkg::SHIFT_K
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // stream
  input  wire logic                         in_valid,
  input  wire logic signed [rpd_pkg::DW-1:0] in_data,
  input  wire logic                         integrator_on,
  output logic                              out_valid,
  output logic signed [rpd_pkg::DW-1:0]     out_data
);
  localparam int AW = rpd_pkg::DW + K;

  logic signed [AW-1:0]          acc;
  logic signed [AW-1:0]          next_acc;
  logic signed [rpd_pkg::DW-1:0] lag;

  generate
    if (K < 1 || K > 16)
    begin : g_chk
      $error("rpd_phase_shift: K out of range");
    end
  endgenerate

  // leaky integrator: about -90 deg above its corner
  assign next_acc = acc + AW'(in_data) - (acc >>> K);
  assign lag      = next_acc[AW-1:K];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc       <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        acc      <= next_acc;
        out_data <= integrator_on ? lag : -lag; // see (R8)
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/rpd_pkg.sv]
// Purpose: shared constants and types of the reactive power datapath
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   all offsets, fields, resets and counts live here
package rpd_pkg;
  // datapath widths
  localparam int DW = 24;
  localparam int PW = 32;
  localparam int GW = 12;
  localparam int OW = 16;
  localparam int EW = 48;

  // register indices
  localparam logic [7:0] IDX_ENERGY      = 8'h04;
  localparam logic [7:0] IDX_WAVE_SEL    = 8'h0D;
  localparam logic [7:0] IDX_NOLOAD_MODE = 8'h0E;
  localparam logic [7:0] IDX_ACC_MODE    = 8'h0F;
  localparam logic [7:0] IDX_GAIN        = 8'h1E;
  localparam logic [7:0] IDX_OFFSET      = 8'h21;
  localparam logic [7:0] IDX_IRQ_EN1     = 8'hD9;
  localparam logic [7:0] IDX_IRQ_EN3     = 8'hDB;
  localparam logic [7:0] IDX_IRQ_STAT1   = 8'hDC;
  localparam logic [7:0] IDX_IRQ_CLR1    = 8'hE0;
  localparam logic [7:0] IDX_WAVE_DATA   = 8'hE1;

  // field positions
  localparam int WAVE_SRC_LSB    = 0;
  localparam int WAVE_RATE_LSB   = 3;
  localparam int NL_SEL_LSB      = 2;
  localparam int ACC_BYACT_BIT   = 2;
  localparam int ACC_ABS_BIT     = 3;
  localparam int ACC_SIGNDIR_BIT = 5;
  localparam int IRQ_NOLOAD_BIT  = 1;
  localparam int IRQ_SIGN_BIT    = 4;
  localparam int EN3_WAVE_BIT    = 5;
  localparam logic [2:0] WAVE_SRC_REACTIVE = 3'h1;

  // reset values
  localparam logic [GW-1:0] RST_GAIN   = 12'h000;
  localparam logic [OW-1:0] RST_OFFSET = 16'h0000;
  localparam logic [7:0]    RST_BYTE   = 8'h00;

  // timing
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint WAVE_BASE_SPS = 25_600;
  localparam int     WAVE_BASE_DIV = int'(CLK_HZ / WAVE_BASE_SPS);

  // no-load thresholds in ppm of multiplier full scale
  localparam longint NL_PPM1 = 150;
  localparam longint NL_PPM2 = 75;
  localparam longint NL_PPM3 = 37;

  // filter shifts
  localparam int SHIFT_K   = 6;
  localparam int LPF_SHIFT = 8;

  typedef struct packed {
    logic signed [DW-1:0] volt;
    logic signed [DW-1:0] curr;
  } rpd_samples_t;
endpackage

// [rtl/rpd_reactive_power_datapath.sv]
// Purpose: reactive power datapath with gain, offset, sign and no-load detection
// Assumes: samples and integrator flag come from logic on pclk
// Notes:   APB slave with zero wait states; registers at four times their index
//
// What this block does
// (R1) multiply voltage by 90 deg shifted current, lowpass
// (R2) lowpass matches active power second filter
// (R3) reactive samples on waveform path, four rates
// (R4) gain scales by one plus gain/4096
// (R5) gain LSB same as active gain
// (R6) add signed 16-bit offset correction
// (R7) 256 offset LSBs equal one waveform LSB
// (R8) shift -90 integrator on, +90 off
// (R9) result signed, sign follows phase angle
// (R10) sign change sets flag, irq if enabled
// (R11) select clear: positive to negative sets flag
// (R12) select set: negative to positive sets flag
// (R13) below no-load: stop accumulating, set flag
// (R14) no-load flag raises irq if enabled
// (R15) no-load select: off or three thresholds
// (R16) signed, by-active-sign or absolute accumulation
// (R17) status flags sticky until software clears
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rpd_reactive_power_datapath #(
  parameter int WAVE_DIV = rpd_pkg::WAVE_BASE_DIV,
  parameter int LPF_SH   = rpd_pkg::LPF_SHIFT
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // sample streams
  input  wire logic                  sample_valid,
  input  wire rpd_pkg::rpd_samples_t samples,
  input  wire logic                  integrator_on,
  input  wire logic                  active_negative,
  // waveform path
  output logic                       wave_valid,
  output logic [rpd_pkg::DW-1:0]     wave_data,
  // status
  output logic                       noload_active,
  output logic                       irq
);
  localparam int DW = rpd_pkg::DW;
  localparam int PW = rpd_pkg::PW;
  localparam int GW = rpd_pkg::GW;
  localparam int OW = rpd_pkg::OW;
  localparam int EW = rpd_pkg::EW;
  localparam int LW = PW + 16;
  localparam longint FS = longint'(1) <<< (PW - 1);
  localparam logic [PW-1:0] THR1 = PW'(FS * rpd_pkg::NL_PPM1 / 1_000_000);
  localparam logic [PW-1:0] THR2 = PW'(FS * rpd_pkg::NL_PPM2 / 1_000_000);
  localparam logic [PW-1:0] THR3 = PW'(FS * rpd_pkg::NL_PPM3 / 1_000_000);
  localparam logic [GW+1:0] UNITY = 14'h1000;

  generate
    if (WAVE_DIV < 2 || WAVE_DIV > 65535 || LPF_SH < 1 || LPF_SH > 16)
    begin : g_chk
      $error("rpd_reactive_power_datapath: parameter out of range");
    end
  endgenerate

  // registers
  logic [GW-1:0] reactive_gain;
  logic [OW-1:0] reactive_offset;
  logic [7:0]    waveform_select_reg;
  logic [7:0]    noload_mode_reg;
  logic [7:0]    accumulation_mode_reg;
  logic [7:0]    metering_irq_enable_1;
  logic [7:0]    metering_irq_enable_3;
  logic [7:0]    metering_irq_status_1;
  logic [EW-1:0] energy;

  // apb decode
  logic [7:0] idx;
  logic       wr;
  logic       hit;
  logic       aligned;
  logic [31:0] rdata;
  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign wr      = psel && penable && pwrite && hit;
  assign hit     = aligned && (idx == rpd_pkg::IDX_ENERGY
                || idx == rpd_pkg::IDX_WAVE_SEL || idx == rpd_pkg::IDX_NOLOAD_MODE
                || idx == rpd_pkg::IDX_ACC_MODE || idx == rpd_pkg::IDX_GAIN
                || idx == rpd_pkg::IDX_OFFSET || idx == rpd_pkg::IDX_IRQ_EN1
                || idx == rpd_pkg::IDX_IRQ_EN3 || idx == rpd_pkg::IDX_IRQ_STAT1
                || idx == rpd_pkg::IDX_IRQ_CLR1 || idx == rpd_pkg::IDX_WAVE_DATA);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (idx)
      rpd_pkg::IDX_ENERGY:      rdata = energy[EW-1:EW-32];
      rpd_pkg::IDX_WAVE_SEL:    rdata = {24'h000000, waveform_select_reg};
      rpd_pkg::IDX_NOLOAD_MODE: rdata = {24'h000000, noload_mode_reg};
      rpd_pkg::IDX_ACC_MODE:    rdata = {24'h000000, accumulation_mode_reg};
      rpd_pkg::IDX_GAIN:        rdata = {20'h00000, reactive_gain};
      rpd_pkg::IDX_OFFSET:      rdata = {16'h0000, reactive_offset};
      rpd_pkg::IDX_IRQ_EN1:     rdata = {24'h000000, metering_irq_enable_1};
      rpd_pkg::IDX_IRQ_EN3:     rdata = {24'h000000, metering_irq_enable_3};
      rpd_pkg::IDX_IRQ_STAT1:   rdata = {24'h000000, metering_irq_status_1};
      rpd_pkg::IDX_WAVE_DATA:   rdata = {{(32-DW){wave_data[DW-1]}}, wave_data};
      default:                  rdata = 32'h0000_0000;
    endcase
  end

  // read data is latched in the setup phase so the access needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= hit ? rdata : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reactive_gain         <= rpd_pkg::RST_GAIN;
      reactive_offset       <= rpd_pkg::RST_OFFSET;
      waveform_select_reg   <= rpd_pkg::RST_BYTE;
      noload_mode_reg       <= rpd_pkg::RST_BYTE;
      accumulation_mode_reg <= rpd_pkg::RST_BYTE;
      metering_irq_enable_1 <= rpd_pkg::RST_BYTE;
      metering_irq_enable_3 <= rpd_pkg::RST_BYTE;
    end
    else if (wr)
    begin
      unique case (idx)
        rpd_pkg::IDX_GAIN:        reactive_gain <= pwdata[GW-1:0];
        rpd_pkg::IDX_OFFSET:      reactive_offset <= pwdata[OW-1:0];
        rpd_pkg::IDX_WAVE_SEL:    waveform_select_reg <= pwdata[7:0];
        rpd_pkg::IDX_NOLOAD_MODE: noload_mode_reg <= pwdata[7:0];
        rpd_pkg::IDX_ACC_MODE:    accumulation_mode_reg <= pwdata[7:0];
        rpd_pkg::IDX_IRQ_EN1:     metering_irq_enable_1 <= pwdata[7:0];
        rpd_pkg::IDX_IRQ_EN3:     metering_irq_enable_3 <= pwdata[7:0];
        default:                  ;
      endcase
    end
  end

  // phase shift and multiply
  logic                 sh_valid;
  logic signed [DW-1:0] sh_curr;
  logic signed [DW-1:0] volt_d;
  logic                 mul_valid;
  logic signed [PW-1:0] prod;
  logic signed [2*DW-1:0] full_prod;

  rpd_phase_shift #(
    .K(rpd_pkg::SHIFT_K)
  ) u_shift (
    .pclk          (pclk),
    .presetn       (presetn),
    .in_valid      (sample_valid),
    .in_data       (samples.curr),
    .integrator_on (integrator_on),
    .out_valid     (sh_valid),
    .out_data      (sh_curr)
  );

  // sign of the shift follows the integrator so q > 0 for 0..+90 deg either way
  assign full_prod = volt_d * sh_curr; // see (R1) (R9)

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      volt_d    <= '0;
      mul_valid <= 1'b0;
      prod      <= '0;
    end
    else
    begin
      if (sample_valid)
        volt_d <= samples.volt;
      mul_valid <= sh_valid;
      if (sh_valid)
        prod <= full_prod[2*DW-2 -: PW]; // see (R1)
    end
  end

  // lowpass: one pole, same response as the active power filter
  logic signed [LW-1:0] lpf_acc;
  logic signed [LW-1:0] next_lpf;
  logic signed [PW-1:0] lpf_out;
  logic                 lpf_valid;
  assign next_lpf = lpf_acc + ((LW'(prod) <<< 16) - lpf_acc) / (LW'(1) <<< LPF_SH); // see (R2)
  assign lpf_out  = lpf_acc[LW-1:16];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lpf_acc   <= '0;
      lpf_valid <= 1'b0;
    end
    else
    begin
      lpf_valid <= mul_valid;
      if (mul_valid)
        lpf_acc <= next_lpf; // see (R1) (R2)
    end
  end

  // gain and offset; offset has 8 fraction bits below the waveform LSB
  logic signed [GW+1:0]  gain_factor;
  logic signed [PW+GW+1:0] gain_prod;
  logic signed [PW-1:0]  scaled;
  logic signed [PW-1:0]  q;
  logic signed [PW-1:0]  q_abs;
  logic                  q_valid;
  assign gain_factor = $signed(UNITY) + (GW+2)'($signed(reactive_gain)); // see (R4) (R5)
  assign gain_prod   = lpf_out * gain_factor;
  assign scaled      = gain_prod[PW+GW-1:GW]; // see (R4)

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q       <= '0;
      q_valid <= 1'b0;
    end
    else
    begin
      q_valid <= lpf_valid;
      if (lpf_valid)
        q <= scaled + PW'($signed(reactive_offset)); // see (R6) (R7)
    end
  end

  // no-load detection on q, the filtered multiplier output after gain and offset
  logic [1:0]    nl_sel;
  logic [PW-1:0] nl_thr;
  logic          below;
  assign nl_sel = noload_mode_reg[rpd_pkg::NL_SEL_LSB +: 2];
  assign q_abs  = q[PW-1] ? -q : q;
  assign nl_thr = (nl_sel == 2'h1) ? THR1 :
                  (nl_sel == 2'h2) ? THR2 : THR3; // see (R15)
  assign below  = (nl_sel != 2'h0) && (q_abs < $signed(nl_thr)); // see (R13) (R15)

  // sign transition detection
  logic last_neg;
  logic have_last;
  logic dir_up;
  logic sign_event;
  logic noload_event;
  assign dir_up       = accumulation_mode_reg[rpd_pkg::ACC_SIGNDIR_BIT];
  assign sign_event   = q_valid && have_last && (dir_up ?
                        (last_neg && !q[PW-1]) :  // see (R12)
                        (!last_neg && q[PW-1]));  // see (R11) (R10)
  assign noload_event = q_valid && below; // see (R13)

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_neg      <= 1'b0;
      have_last     <= 1'b0;
      noload_active <= 1'b0;
    end
    else if (q_valid)
    begin
      last_neg      <= q[PW-1];
      have_last     <= 1'b1;
      noload_active <= below;
    end
  end

  // energy accumulation; absolute wins over by-active-sign
  logic by_act;
  logic absm;
  logic signed [PW-1:0] acc_term;
  assign by_act   = accumulation_mode_reg[rpd_pkg::ACC_BYACT_BIT];
  assign absm     = accumulation_mode_reg[rpd_pkg::ACC_ABS_BIT];
  assign acc_term = absm ? q_abs :
                    (by_act && active_negative) ? -q : q; // see (R16)

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      energy <= '0;
    else if (q_valid && !below)
      energy <= energy + EW'(acc_term); // see (R13) (R16)
  end

  // sticky status: set wins over a write-one clear
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  assign set_bits = (8'(sign_event) << rpd_pkg::IRQ_SIGN_BIT)
                  | (8'(noload_event) << rpd_pkg::IRQ_NOLOAD_BIT);
  assign clr_bits = (wr && idx == rpd_pkg::IDX_IRQ_CLR1) ? pwdata[7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      metering_irq_status_1 <= rpd_pkg::RST_BYTE;
    else
      metering_irq_status_1 <= (metering_irq_status_1 & ~clr_bits) | set_bits; // see (R17)
  end

  // level interrupt while any enabled flag stands
  assign irq = |(metering_irq_status_1 & metering_irq_enable_1); // see (R10) (R14)

  // waveform path: base tick at the top rate, decimated by 1, 2, 4 or 8
  logic [15:0] tick_cnt;
  logic        tick;
  logic [2:0]  dec_cnt;
  logic [1:0]  rate_sel;
  logic [2:0]  dec_mask;
  logic        wave_on;
  logic        wave_fire;
  assign tick     = (tick_cnt == 16'(WAVE_DIV - 1));
  assign rate_sel = waveform_select_reg[rpd_pkg::WAVE_RATE_LSB +: 2];
  assign dec_mask = 3'((4'h1 << rate_sel) - 4'h1);
  assign wave_on  = metering_irq_enable_3[rpd_pkg::EN3_WAVE_BIT]
                 && waveform_select_reg[rpd_pkg::WAVE_SRC_LSB +: 3]
                    == rpd_pkg::WAVE_SRC_REACTIVE; // see (R3)
  // data only moves with its pulse, so a slow reader sees one sample
  assign wave_fire = tick && wave_on && ((dec_cnt & dec_mask) == 3'h0); // see (R3)

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt   <= 16'h0000;
      dec_cnt    <= 3'h0;
      wave_valid <= 1'b0;
      wave_data  <= '0;
    end
    else
    begin
      tick_cnt   <= tick ? 16'h0000 : tick_cnt + 16'h0001;
      if (tick)
        dec_cnt <= dec_cnt + 3'h1;
      wave_valid <= wave_fire;
      if (wave_fire)
        wave_data <= q[PW-1 -: DW]; // see (R7)
    end
  end
endmodule
`default_nettype wire

// [sim/rpd_checker_sva.sv]
// Purpose: port-level checks of the reactive power datapath
// Assumes: WAVE_DIV handed on from the design instance
// Notes:   flag and irq timing follow the five-cycle sample latency
`timescale 1ns/10ps
`default_nettype none
module rpd_checker #(
  parameter int WAVE_DIV = 8
) (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // streams and status
  input wire logic                  sample_valid,
  input wire rpd_pkg::rpd_samples_t samples,
  input wire logic                  integrator_on,
  input wire logic                  active_negative,
  input wire logic                  wave_valid,
  input wire logic [23:0]           wave_data,
  input wire logic                  noload_active,
  input wire logic                  irq
);
  logic [31:0] gap;
  logic        seen;
  wire         wr = psel && penable && pwrite;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a write may retune the rate, so spacing is only judged between quiet pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap  <= 32'h0;
      seen <= 1'b0;
    end
    else if (wave_valid || wr)
    begin
      gap  <= 32'h0;
      seen <= wave_valid && !wr;
    end
    else if (gap != 32'hFFFF_FFFF)
      gap <= gap + 32'h1;
  end

  AST_READY_HIGH: assert property (pready)
    else $error("pready low out of reset");
  AST_MISALIGNED_ERR: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access without pslverr");
  AST_WAVE_PULSE: assert property (wave_valid |=> !wave_valid)
    else $error("wave_valid longer than one cycle");
  AST_WAVE_HOLD: assert property ($changed(wave_data) |-> wave_valid)
    else $error("wave_data changed without wave_valid");
  AST_WAVE_SPACING: assert property (wave_valid && seen |-> gap >= 32'(WAVE_DIV - 1))
    else $error("wave samples closer than the base divider");
  AST_IRQ_HOLD: assert property (irq && !wr |=> irq)
    else $error("irq dropped without a register write");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(wr) || $past(sample_valid, 5))
    else $error("irq rose without a write or a sample five cycles back");
  AST_NOLOAD_TIMING: assert property ($changed(noload_active) |->
    $past(wr) || $past(sample_valid, 4) || $past(sample_valid, 5))
    else $error("noload_active moved without a sample");
endmodule
bind rpd_reactive_power_datapath rpd_checker #(.WAVE_DIV(WAVE_DIV)) rpd_checker_inst (.*);
`default_nettype wire

// [sim/rpd_reactive_power_datapath_tb.sv]
// Purpose: self-checking bench of the reactive power datapath
// Assumes: zero input samples until the last scenarios, so the offset sets the result
// Notes:   WAVE_DIV shortened to 8 cycles
`timescale 1ns/10ps
`default_nettype none
module rpd_reactive_power_datapath_tb;
  localparam int WDIV = 8;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                  sample_valid, integrator_on, active_negative;
  logic                  wave_valid, noload_active, irq;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [23:0]           wave_data;
  logic signed [23:0]    volt, curr;
  rpd_pkg::rpd_samples_t samples;
  int                    mismatches, tests_run, n;

  rpd_reactive_power_datapath #(.WAVE_DIV(WDIV)) rpd_reactive_power_datapath_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .samples(samples), .integrator_on(integrator_on),
    .active_negative(active_negative), .wave_valid(wave_valid), .wave_data(wave_data),
    .noload_active(noload_active), .irq(irq));
  rpd_sample_source rpd_sample_source_inst (.pclk(pclk), .presetn(presetn), .volt(volt),
    .curr(curr), .sample_valid(sample_valid), .samples(samples));

  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      mismatches++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    xfer(1'b1, {2'h0, i, 2'h0}, d);
  endtask

  task automatic rdm(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, {2'h0, i, 2'h0}, 32'h0);
    chk(rd & m, e);
  endtask

  // samples every 4 cycles plus 5 cycles of latency
  task automatic settle;
    repeat (24) @(posedge pclk);
    #1;
  endtask

  task automatic chk_irq(input logic e);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic wait_wave;
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (wave_valid !== 1'b1 && n < 300);
  endtask

  task automatic t_regs;
    rdm(rpd_pkg::IDX_GAIN, 32'hFFFF_FFFF, {20'h0, rpd_pkg::RST_GAIN});
    rdm(rpd_pkg::IDX_OFFSET, 32'hFFFF_FFFF, {16'h0, rpd_pkg::RST_OFFSET});
    wr(rpd_pkg::IDX_GAIN, 32'hFFFF_FFFF);
    rdm(rpd_pkg::IDX_GAIN, 32'hFFFF_FFFF, 32'h0000_0FFF);
    wr(rpd_pkg::IDX_OFFSET, 32'hFFFF_FFFF);
    rdm(rpd_pkg::IDX_OFFSET, 32'hFFFF_FFFF, 32'h0000_FFFF);
    wr(rpd_pkg::IDX_GAIN, 32'h0);
    xfer(1'b0, 12'h3FC, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    xfer(1'b1, 12'h079, 32'h0000_0001);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_sign;
    wr(rpd_pkg::IDX_WAVE_SEL, 32'h1);
    wr(rpd_pkg::IDX_IRQ_EN3, 32'h20);
    wr(rpd_pkg::IDX_OFFSET, 32'h0100);
    settle;
    wait_wave;
    chk({8'h0, wave_data}, 32'h1);
    rdm(rpd_pkg::IDX_WAVE_DATA, 32'hFFFF_FFFF, 32'h1);
    wr(rpd_pkg::IDX_IRQ_CLR1, 32'hFF);
    wr(rpd_pkg::IDX_OFFSET, 32'hFF00);
    settle;
    wait_wave;
    chk({8'h0, wave_data}, 32'h00FF_FFFF);
    rdm(rpd_pkg::IDX_IRQ_STAT1, 32'hFF, 32'h10);
    wr(rpd_pkg::IDX_IRQ_EN1, 32'h10);
    chk_irq(1'b1);
    wr(rpd_pkg::IDX_OFFSET, 32'h0100);
    settle;
    rdm(rpd_pkg::IDX_IRQ_STAT1, 32'h10, 32'h10);
    wr(rpd_pkg::IDX_IRQ_CLR1, 32'h10);
    chk_irq(1'b0);
    wr(rpd_pkg::IDX_ACC_MODE, 32'h20);
    wr(rpd_pkg::IDX_OFFSET, 32'hFF00);
    settle;
    rdm(rpd_pkg::IDX_IRQ_STAT1, 32'h10, 32'h0);
    wr(rpd_pkg::IDX_OFFSET, 32'h0100);
    settle;
    rdm(rpd_pkg::IDX_IRQ_STAT1, 32'h10, 32'h10);
    wr(rpd_pkg::IDX_IRQ_EN1, 32'h0);
    wr(rpd_pkg::IDX_ACC_MODE, 32'h0);
  endtask

  // dc samples: the shift sign flips with the integrator, so q changes sign
  task automatic t_shift;
    volt          <= 24'h10_0000;
    curr          <= 24'h10_0000;
    integrator_on <= 1'b1;
    repeat (400) @(posedge pclk);
    wr(rpd_pkg::IDX_IRQ_CLR1, 32'hFF);
    integrator_on <= 1'b0;
    repeat (400) @(posedge pclk);
    rdm(rpd_pkg::IDX_IRQ_STAT1, 32'h10, 32'h10);
  endtask

  // q is negative here; judge the direction the energy register moves
  task automatic t_energy(input logic [7:0] mode, input logic up);
    logic [31:0] e0;
    wr(rpd_pkg::IDX_ACC_MODE, {24'h0, mode});
    xfer(1'b0, {2'h0, rpd_pkg::IDX_ENERGY, 2'h0}, 32'h0);
    e0 = rd;
    settle;
    xfer(1'b0, {2'h0, rpd_pkg::IDX_ENERGY, 2'h0}, 32'h0);
    chk({31'h0, $signed(rd - e0) > 0}, {31'h0, up});
  endtask

  task automatic t_noload;
    wr(rpd_pkg::IDX_OFFSET, 32'h0);
    wr(rpd_pkg::IDX_IRQ_EN1, 32'h02);
    for (int s = 1; s < 4; s++)
    begin
      wr(rpd_pkg::IDX_IRQ_CLR1, 32'hFF);
      wr(rpd_pkg::IDX_NOLOAD_MODE, 32'(s) << 2);
      settle;
      chk({31'h0, noload_active}, 32'h1);
      rdm(rpd_pkg::IDX_IRQ_STAT1, 32'h02, 32'h02);
      chk_irq(1'b1);
      wr(rpd_pkg::IDX_NOLOAD_MODE, 32'h0);
      settle;
      rdm(rpd_pkg::IDX_IRQ_STAT1, 32'h02, 32'h02);
      wr(rpd_pkg::IDX_IRQ_CLR1, 32'h02);
      settle;
      rdm(rpd_pkg::IDX_IRQ_STAT1, 32'h02, 32'h0);
      chk({31'h0, noload_active}, 32'h0);
    end
  endtask

  task automatic t_rate;
    for (int r = 0; r < 4; r++)
    begin
      wr(rpd_pkg::IDX_WAVE_SEL, 32'h1 | (32'(r) << 3));
      wait_wave;
      wait_wave;
      chk(32'(n), 32'(WDIV << r));
    end
    wr(rpd_pkg::IDX_IRQ_EN3, 32'h0);
    wait_wave;
    chk(32'(n), 32'h0000_012C);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial
  begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    wrap_up;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, integrator_on, active_negative} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    volt = 24'h0;
    curr = 24'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sign;
    t_noload;
    t_rate;
    t_shift;
    t_energy(8'h00, 1'b0);
    active_negative <= 1'b1;
    t_energy(8'h04, 1'b1);
    active_negative <= 1'b0;
    t_energy(8'h0C, 1'b1);
    wrap_up;
  end
endmodule
`default_nettype wire

// [sim/rpd_sample_source.sv]
// Purpose: stand-in for the voltage and current sample streams
// Assumes: one sample pair every PERIOD cycles once out of reset
// Notes:   between pulses the data lines carry garbage on purpose
`timescale 1ns/10ps
`default_nettype none
module rpd_sample_source #(
  parameter int PERIOD = 4
) (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // requested values
  input wire logic signed [23:0] volt,
  input wire logic signed [23:0] curr,
  // stream
  output logic                   sample_valid,
  output rpd_pkg::rpd_samples_t  samples
);
  logic [7:0] cnt;
  wire        fire = (cnt == 8'(PERIOD - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt          <= 8'h0;
      sample_valid <= 1'b0;
      samples      <= '0;
    end
    else
    begin
      cnt          <= fire ? 8'h0 : cnt + 8'h1;
      sample_valid <= fire;
      samples      <= fire ? {volt, curr} : ~{volt, curr};
    end
  end
endmodule
`default_nettype wire
